// ===== include/addr_dec_pkg.sv
// address map, field layout and encodings for the processor address decoder
package addr_dec_pkg;

  // target classes; CFG_ADDR is served locally and never forwarded
  typedef enum logic [3:0] {
    TGT_NONE     = 4'b0000,
    TGT_SDRAM    = 4'b0001,
    TGT_BOOT     = 4'b0010,
    TGT_FLASH    = 4'b0011,
    TGT_OPS      = 4'b0100,
    TGT_PCI_MEM  = 4'b0101,
    TGT_PCI_IO   = 4'b0110,
    TGT_PCI_CFG  = 4'b0111,
    TGT_CFG_ADDR = 4'b1000
  } target_e;

  typedef enum logic {
    PH_IDLE = 1'b0,
    PH_FWD  = 1'b1
  } phase_e;

  localparam logic [31:0] SDRAM_BASE    = 32'h0000_0000;
  localparam logic [31:0] SDRAM_LAST    = 32'h07ff_ffff;
  localparam logic [31:0] OPS_BASE      = 32'h7000_0000;
  localparam logic [31:0] OPS_LAST      = 32'h7000_ffff;
  localparam logic [31:0] PCI_MEM_BASE  = 32'h8010_0000;
  localparam logic [31:0] PCI_MEM_LAST  = 32'hfdff_ffff;
  localparam logic [31:0] PCI_IO_BASE   = 32'hfe00_0000;
  localparam logic [31:0] PCI_IO_LAST   = 32'hfebf_ffff;
  localparam logic [31:0] CFG_ADDR_BASE = 32'hfec0_0000;
  localparam logic [31:0] CFG_ADDR_LAST = 32'hfedf_ffff;
  localparam logic [31:0] CFG_DATA_BASE = 32'hfee0_0000;
  localparam logic [31:0] CFG_DATA_LAST = 32'hfeff_ffff;
  localparam logic [31:0] FLASH_BASE    = 32'hff00_0000;
  localparam logic [31:0] FLASH_LAST    = 32'hff7f_ffff;
  localparam logic [31:0] BOOT_BASE     = 32'hff80_0000;
  localparam logic [31:0] BOOT_LAST     = 32'hffff_ffff;

  localparam int BOOT_LINES   = 15;
  localparam int IO_KEEP_BITS = 24;
  localparam int ROW_BITS     = 13;
  localparam int COL_BITS     = 10;
  localparam int BANK_BITS    = 2;
  localparam int COL_POS      = 2;
  localparam int BANK_POS     = 12;
  localparam int ROW_POS      = 14;

  localparam logic [31:0] CFG_ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;
  localparam logic [31:0] WRITE_RDATA    = 32'h0000_0000;

  function automatic logic in_win(input logic [31:0] a, input logic [31:0] lo,
                                  input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage

// ===== include/dec_if.sv
// carrier between the address decoder core and its window decode
`timescale 1ns/1ns
`default_nettype none
interface dec_if;
  import addr_dec_pkg::*;
  logic    [31:0] addr;
  target_e        tgt;
  logic           byte_wide;
  logic    [31:0] fwd_addr;
  modport decoder (input addr, output tgt, output byte_wide, output fwd_addr);
  modport user    (output addr, input tgt, input byte_wide, input fwd_addr);
endinterface
`default_nettype wire

// ===== src/window_decode.sv
// combinational window match and address translation
`timescale 1ns/1ns
`default_nettype none
module window_decode (
  dec_if.decoder d
);
  import addr_dec_pkg::*;

  always_comb begin
    d.tgt       = TGT_NONE;
    d.byte_wide = 1'b0;
    d.fwd_addr  = d.addr;
    if (in_win(d.addr, SDRAM_BASE, SDRAM_LAST)) begin
      d.tgt = TGT_SDRAM;
    end else if (in_win(d.addr, OPS_BASE, OPS_LAST)) begin
      d.tgt       = TGT_OPS;
      d.byte_wide = 1'b1;
    end else if (in_win(d.addr, PCI_MEM_BASE, PCI_MEM_LAST)) begin
      d.tgt = TGT_PCI_MEM;
    end else if (in_win(d.addr, PCI_IO_BASE, PCI_IO_LAST)) begin
      d.tgt      = TGT_PCI_IO;
      d.fwd_addr = {{(32-IO_KEEP_BITS){1'b0}}, d.addr[IO_KEEP_BITS-1:0]};
    end else if (in_win(d.addr, CFG_ADDR_BASE, CFG_ADDR_LAST)) begin
      d.tgt = TGT_CFG_ADDR;
    end else if (in_win(d.addr, CFG_DATA_BASE, CFG_DATA_LAST)) begin
      d.tgt = TGT_PCI_CFG;
    end else if (in_win(d.addr, FLASH_BASE, FLASH_LAST)) begin
      d.tgt       = TGT_FLASH;
      d.byte_wide = 1'b1;
    end else if (in_win(d.addr, BOOT_BASE, BOOT_LAST)) begin
      // only the low lines reach the part, so it repeats over the whole region
      d.tgt       = TGT_BOOT;
      d.byte_wide = 1'b1;
      d.fwd_addr  = {{(32-BOOT_LINES){1'b0}}, d.addr[BOOT_LINES-1:0]};
    end
  end

endmodule
`default_nettype wire

// ===== src/processor_address_decoder.sv
// processor address decoder: window steering, translation and pci config pair
`timescale 1ns/1ns
`default_nettype none
module processor_address_decoder (
  input  wire logic                           ref_clk,
  input  wire logic                           nrst,
  input  wire logic                           req_valid,
  input  wire logic                           req_write,
  input  wire logic [31:0]                    req_addr,
  input  wire logic [31:0]                    req_wdata,
  output logic                                req_ready,
  output logic                                req_ack,
  output logic [31:0]                         req_rdata,
  output logic                                tgt_valid,
  output addr_dec_pkg::target_e               tgt_sel,
  output logic                                tgt_write,
  output logic [31:0]                         tgt_addr,
  output logic [31:0]                         tgt_wdata,
  output logic                                tgt_byte_wide,
  output logic [addr_dec_pkg::ROW_BITS-1:0]   sdram_row,
  output logic [addr_dec_pkg::COL_BITS-1:0]   sdram_col,
  output logic [addr_dec_pkg::BANK_BITS-1:0]  sdram_bank,
  input  wire logic                           tgt_ack,
  input  wire logic [31:0]                    tgt_rdata
);
  import addr_dec_pkg::*;

  typedef struct packed {
    phase_e                phase;
    logic                  req_ready;
    logic                  req_ack;
    logic [31:0]           req_rdata;
    logic                  tgt_valid;
    target_e               tgt_sel;
    logic                  tgt_write;
    logic [31:0]           tgt_addr;
    logic [31:0]           tgt_wdata;
    logic                  tgt_byte_wide;
    logic [ROW_BITS-1:0]   sdram_row;
    logic [COL_BITS-1:0]   sdram_col;
    logic [BANK_BITS-1:0]  sdram_bank;
    logic [31:0]           cfg_addr;
  } state_s;

  localparam state_s STATE_RESET = '{
    phase:         PH_IDLE,
    req_ready:     1'b1,
    req_ack:       1'b0,
    req_rdata:     32'h0000_0000,
    tgt_valid:     1'b0,
    tgt_sel:       TGT_NONE,
    tgt_write:     1'b0,
    tgt_addr:      32'h0000_0000,
    tgt_wdata:     32'h0000_0000,
    tgt_byte_wide: 1'b0,
    sdram_row:     '0,
    sdram_col:     '0,
    sdram_bank:    '0,
    cfg_addr:      CFG_ADDR_RESET
  };

  state_s s;
  state_s next_s;
  logic   take;

  dec_if dec ();

  assign dec.addr = req_addr;

  window_decode u_window_decode (
    .d (dec)
  );

  assign take = req_valid && s.req_ready;

  always_comb begin
    next_s         = s;
    next_s.req_ack = 1'b0;
    case (s.phase)
      PH_IDLE: begin
        if (take) begin
          case (dec.tgt)
            TGT_CFG_ADDR: begin
              // served here; the pci side sees nothing until the data access
              if (req_write) begin
                next_s.cfg_addr = req_wdata;
              end
              next_s.req_ack   = 1'b1;
              next_s.req_rdata = req_write ? WRITE_RDATA : s.cfg_addr;
            end
            TGT_NONE: begin
              next_s.req_ack   = 1'b1;
              next_s.req_rdata = UNMAPPED_RDATA;
            end
            default: begin
              if (dec.tgt == TGT_BOOT && req_write) begin
                // acknowledged so the processor does not hang, never driven out
                next_s.req_ack   = 1'b1;
                next_s.req_rdata = WRITE_RDATA;
              end else begin
                // each store, flash command words included, is one target cycle
                next_s.phase         = PH_FWD;
                next_s.req_ready     = 1'b0;
                next_s.tgt_valid     = 1'b1;
                next_s.tgt_sel       = dec.tgt;
                next_s.tgt_write     = req_write;
                next_s.tgt_wdata     = req_wdata;
                next_s.tgt_byte_wide = dec.byte_wide;
                next_s.tgt_addr      = (dec.tgt == TGT_PCI_CFG) ? s.cfg_addr
                                                                 : dec.fwd_addr;
                next_s.sdram_row  = req_addr[ROW_POS+ROW_BITS-1:ROW_POS];
                next_s.sdram_bank = req_addr[BANK_POS+BANK_BITS-1:BANK_POS];
                next_s.sdram_col  = req_addr[COL_POS+COL_BITS-1:COL_POS];
              end
            end
          endcase
        end
      end
      PH_FWD: begin
        // outputs hold steady until the target answers
        if (tgt_ack) begin
          next_s.phase     = PH_IDLE;
          next_s.tgt_valid = 1'b0;
          next_s.req_ready = 1'b1;
          next_s.req_ack   = 1'b1;
          next_s.req_rdata = s.tgt_write ? WRITE_RDATA : tgt_rdata;
        end
      end
      default: begin
        next_s = STATE_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign req_ready     = s.req_ready;
  assign req_ack       = s.req_ack;
  assign req_rdata     = s.req_rdata;
  assign tgt_valid     = s.tgt_valid;
  assign tgt_sel       = s.tgt_sel;
  assign tgt_write     = s.tgt_write;
  assign tgt_addr      = s.tgt_addr;
  assign tgt_wdata     = s.tgt_wdata;
  assign tgt_byte_wide = s.tgt_byte_wide;
  assign sdram_row     = s.sdram_row;
  assign sdram_col     = s.sdram_col;
  assign sdram_bank    = s.sdram_bank;

  // checks use the package windows directly, independent of the decode module
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  a_unmapped_quiet: assert property (
    take && !in_win(req_addr, SDRAM_BASE, SDRAM_LAST)
      && !in_win(req_addr, OPS_BASE, OPS_LAST)
      && !in_win(req_addr, PCI_MEM_BASE, BOOT_LAST)
    |=> req_ack && !tgt_valid && req_rdata == UNMAPPED_RDATA)
    else $error("unmapped access was forwarded or read wrong");

  a_rom_write_drop: assert property (
    take && req_write && in_win(req_addr, BOOT_BASE, BOOT_LAST)
    |=> req_ack && !tgt_valid)
    else $error("boot write reached the target");

  a_rom_alias_addr: assert property (
    take && !req_write && in_win(req_addr, BOOT_BASE, BOOT_LAST)
    |=> tgt_valid && tgt_sel == TGT_BOOT && tgt_byte_wide
        && tgt_addr == {17'h0, $past(req_addr[14:0])})
    else $error("boot read address not folded to low lines");

  a_io_clear_top: assert property (
    take && in_win(req_addr, PCI_IO_BASE, PCI_IO_LAST)
    |=> tgt_sel == TGT_PCI_IO && tgt_addr[31:24] == 8'h00
        && tgt_addr[23:0] == $past(req_addr[23:0]))
    else $error("pci io address not translated");

  a_sdram_split: assert property (
    take && in_win(req_addr, SDRAM_BASE, SDRAM_LAST)
    |=> tgt_sel == TGT_SDRAM && tgt_addr == $past(req_addr)
        && {sdram_row, sdram_bank, sdram_col} == $past(req_addr[26:2]))
    else $error("sdram address split wrong");

  a_cfg_addr_store: assert property (
    take && req_write && in_win(req_addr, CFG_ADDR_BASE, CFG_ADDR_LAST)
    |=> req_ack && !tgt_valid && s.cfg_addr == $past(req_wdata))
    else $error("config address register not written");

  a_cfg_data_target: assert property (
    take && in_win(req_addr, CFG_DATA_BASE, CFG_DATA_LAST)
    |=> tgt_valid && tgt_sel == TGT_PCI_CFG && tgt_addr == $past(s.cfg_addr))
    else $error("config cycle not aimed at stored address");

  a_mem_forward: assert property (
    take && in_win(req_addr, PCI_MEM_BASE, PCI_MEM_LAST)
    |=> tgt_sel == TGT_PCI_MEM && tgt_addr == $past(req_addr))
    else $error("pci memory access not forwarded");

  a_flash_byte: assert property (
    take && in_win(req_addr, FLASH_BASE, FLASH_LAST)
    |=> tgt_sel == TGT_FLASH && tgt_byte_wide && tgt_write == $past(req_write))
    else $error("flash access not byte wide or direction lost");

  a_ops_byte: assert property (
    take && in_win(req_addr, OPS_BASE, OPS_LAST)
    |=> tgt_sel == TGT_OPS && tgt_byte_wide)
    else $error("operations window not byte wide");

  a_fwd_hold: assert property (
    tgt_valid && !tgt_ack |=> tgt_valid && $stable(tgt_addr) && !req_ready)
    else $error("forwarded cycle dropped before answer");

  // a local take on the completion edge may legally raise the ack again
  a_ack_done: assert property (
    tgt_valid && tgt_ack |=> req_ack && !tgt_valid && req_ready
      ##1 (!req_ack || $past(take)))
    else $error("target answer not returned as one pulse");

  // one cycle out at a time, so ready is the inverse of the busy flag
  a_busy_ready: assert property (
    tgt_valid == !req_ready)
    else $error("ready and forwarded cycle disagree");

  a_ack_idle: assert property (
    req_ack |-> !tgt_valid)
    else $error("completion while a cycle is still out");

  a_sdram_wide: assert property (
    take && in_win(req_addr, SDRAM_BASE, SDRAM_LAST)
    |=> tgt_valid && !tgt_byte_wide && tgt_write == $past(req_write))
    else $error("sdram access not forwarded full width");

  a_byte_lanes: assert property (
    tgt_valid && tgt_byte_wide
    |-> tgt_sel == TGT_BOOT || tgt_sel == TGT_FLASH || tgt_sel == TGT_OPS)
    else $error("byte path used for a wide target");

  a_fwd_class: assert property (
    tgt_valid |-> tgt_sel != TGT_NONE && tgt_sel != TGT_CFG_ADDR)
    else $error("local or unmapped class forwarded");

  a_flash_store: assert property (
    take && req_write && in_win(req_addr, FLASH_BASE, FLASH_LAST)
    |=> tgt_valid && tgt_write && tgt_wdata == $past(req_wdata))
    else $error("flash command write not forwarded as is");

  a_read_return: assert property (
    tgt_valid && tgt_ack && !tgt_write |=> req_rdata == $past(tgt_rdata))
    else $error("target read data not returned");

  a_cfg_addr_read: assert property (
    take && !req_write && in_win(req_addr, CFG_ADDR_BASE, CFG_ADDR_LAST)
    |=> req_ack && !tgt_valid && req_rdata == $past(s.cfg_addr))
    else $error("config address register read wrong");

  a_rdata_hold: assert property (
    !req_ack |-> $stable(req_rdata))
    else $error("read data moved without completion");

  a_io_write_data: assert property (
    take && req_write && in_win(req_addr, PCI_IO_BASE, PCI_IO_LAST)
    |=> tgt_valid && tgt_write && tgt_wdata == $past(req_wdata))
    else $error("pci io write not forwarded");

  a_mem_read_dir: assert property (
    take && !req_write && in_win(req_addr, PCI_MEM_BASE, PCI_MEM_LAST)
    |=> tgt_valid && !tgt_write && !tgt_byte_wide)
    else $error("pci memory read direction or width wrong");

  c_cfg_pair: cover property (
    take && req_write && in_win(req_addr, CFG_ADDR_BASE, CFG_ADDR_LAST)
    ##[1:20] take && in_win(req_addr, CFG_DATA_BASE, CFG_DATA_LAST));
  c_boot_read: cover property (take && !req_write && in_win(req_addr, BOOT_BASE, BOOT_LAST));
  c_io_read: cover property (take && in_win(req_addr, PCI_IO_BASE, PCI_IO_LAST));
  c_stalled: cover property (tgt_valid && !tgt_ack ##1 tgt_valid && tgt_ack);
  c_unmapped: cover property (take && in_win(req_addr, SDRAM_LAST + 32'h1, OPS_BASE - 32'h1));

endmodule
`default_nettype wire

// ===== verif/target_model.sv
// far-side target model: answers each forwarded cycle after a settable delay
`timescale 1ns/1ns
`default_nettype none
module target_model (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        tgt_valid,
  input  wire logic        tgt_write,
  input  wire logic [31:0] tgt_addr,
  input  wire logic [3:0]  dly,
  output logic             tgt_ack,
  output logic [31:0]      tgt_rdata
);
  logic [3:0] cnt;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt       <= 4'h0;
      tgt_ack   <= 1'b0;
      tgt_rdata <= 32'h0000_0000;
    end else if (tgt_valid && !tgt_ack && cnt == dly) begin
      // commands and config cycles are answered like any plain access
      tgt_ack   <= 1'b1;
      tgt_rdata <= tgt_write ? ~tgt_rdata : ~tgt_addr;
      cnt       <= 4'h0;
    end else begin
      // data toggles outside the answer so a stale value never passes
      tgt_ack   <= 1'b0;
      tgt_rdata <= ~tgt_rdata;
      cnt       <= (tgt_valid && !tgt_ack) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the processor address decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
  import addr_dec_pkg::*;
  logic        ref_clk   = 1'b0;
  logic        nrst      = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [31:0] req_addr  = 32'h0000_0000;
  logic [31:0] req_wdata = 32'h0000_0000;
  logic [3:0]  dly       = 4'h0;
  logic        req_ready, req_ack, tgt_valid, tgt_write, tgt_byte_wide, tgt_ack;
  logic [31:0] req_rdata, tgt_addr, tgt_wdata, tgt_rdata;
  target_e     tgt_sel;
  logic [12:0] sdram_row;
  logic [9:0]  sdram_col;
  logic [1:0]  sdram_bank;
  int          bad_count = 0;
  int          tests_run = 0;
  logic        fwd, bw, tw, rdy;
  logic [3:0]  sel;
  logic [31:0] ta, twd, rd;
  logic [24:0] rcb;

  always #25 ref_clk = ~ref_clk;

  processor_address_decoder u_processor_address_decoder (
    .ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .req_ack(req_ack),
    .req_rdata(req_rdata), .tgt_valid(tgt_valid), .tgt_sel(tgt_sel), .tgt_write(tgt_write),
    .tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata), .tgt_byte_wide(tgt_byte_wide),
    .sdram_row(sdram_row), .sdram_col(sdram_col), .sdram_bank(sdram_bank),
    .tgt_ack(tgt_ack), .tgt_rdata(tgt_rdata));

  target_model u_target_model (
    .ref_clk(ref_clk), .nrst(nrst), .tgt_valid(tgt_valid), .tgt_write(tgt_write),
    .tgt_addr(tgt_addr), .dly(dly), .tgt_ack(tgt_ack), .tgt_rdata(tgt_rdata));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one processor access; records what was forwarded while waiting for the ack
  task automatic acc(input logic w, input logic [31:0] a);
    int n;
    n = 0;
    fwd = 1'b0;
    rdy = 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= a ^ 32'h5a5a_a5a5;
    @(negedge ref_clk);
    while (req_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
      if (tgt_valid === 1'b1) begin
        fwd = 1'b1;
        sel = tgt_sel;
        ta  = tgt_addr;
        bw  = tgt_byte_wide;
        tw  = tgt_write;
        twd = tgt_wdata;
        rcb = {sdram_row, sdram_bank, sdram_col};
        rdy = rdy & req_ready;
      end
    end while (req_ack !== 1'b1 && n < 40);
    chk({31'h0, req_ack}, 32'h1);
    rd = req_rdata;
    @(negedge ref_clk);
    chk({31'h0, req_ack}, 32'h0);
  endtask

  task automatic fcase(input logic w, input logic [31:0] a, input target_e s,
                       input logic [31:0] t, input logic b);
    acc(w, a);
    chk({25'h0, fwd, bw, tw, sel}, {25'h0, 1'b1, b, w, s});
    chk(ta, t);
    chk({31'h0, rdy}, 32'h0);
    chk(rd, w ? WRITE_RDATA : ~t);
    if (w) chk(twd, a ^ 32'h5a5a_a5a5);
  endtask

  task automatic lcase(input logic w, input logic [31:0] a, input logic [31:0] e);
    acc(w, a);
    chk({31'h0, fwd}, 32'h0);
    chk(rd, e);
  endtask

  initial begin
    #200000;
    bad_count++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    chk({29'h0, req_ready, req_ack, tgt_valid}, 32'h4);
    chk(req_rdata, 32'h0);
    lcase(1'b0, 32'hfec0_0000, 32'h0);
    fcase(1'b0, 32'h0000_0000, TGT_SDRAM, 32'h0000_0000, 1'b0);
    fcase(1'b1, 32'h0512_3458, TGT_SDRAM, 32'h0512_3458, 1'b0);
    chk({7'h0, rcb}, {7'h0, 25'(32'h0512_3458 >> 2)});
    fcase(1'b0, 32'h07ff_fffc, TGT_SDRAM, 32'h07ff_fffc, 1'b0);
    lcase(1'b0, 32'h0800_0000, 32'h0);
    fcase(1'b1, 32'h7000_0010, TGT_OPS, 32'h7000_0010, 1'b1);
    lcase(1'b1, 32'h8000_0000, 32'h0);
    dly <= 4'h6;
    fcase(1'b0, 32'h8010_0000, TGT_PCI_MEM, 32'h8010_0000, 1'b0);
    dly <= 4'h0;
    fcase(1'b0, 32'hfdff_fffc, TGT_PCI_MEM, 32'hfdff_fffc, 1'b0);
    fcase(1'b0, 32'hfe00_0004, TGT_PCI_IO, 32'h0000_0004, 1'b0);
    fcase(1'b1, 32'hfe80_0000, TGT_PCI_IO, 32'h0080_0000, 1'b0);
    fcase(1'b0, 32'hff00_0000, TGT_FLASH, 32'hff00_0000, 1'b1);
    // command writes stay clear of the first sector
    fcase(1'b1, 32'hff7f_5555, TGT_FLASH, 32'hff7f_5555, 1'b1);
    fcase(1'b0, 32'hff80_0000, TGT_BOOT, 32'h0000_0000, 1'b1);
    fcase(1'b0, 32'hfff0_0100, TGT_BOOT, 32'h0000_0100, 1'b1);
    fcase(1'b0, 32'hffff_ffff, TGT_BOOT, 32'h0000_7fff, 1'b1);
    lcase(1'b1, 32'hff80_0010, WRITE_RDATA);
    // config address written as the window base xor the bench data pattern, then read back
    lcase(1'b1, 32'hfec0_0000, WRITE_RDATA);
    lcase(1'b0, 32'hfec0_0000, 32'hfec0_0000 ^ 32'h5a5a_a5a5);
    // a device's bars are read through the pair before its window is used
    fcase(1'b0, 32'hfee0_0000, TGT_PCI_CFG, 32'hfec0_0000 ^ 32'h5a5a_a5a5, 1'b0);
    acc(1'b1, 32'hfee0_0000);
    chk({28'h0, sel}, {28'h0, TGT_PCI_CFG});
    chk(ta, 32'hfec0_0000 ^ 32'h5a5a_a5a5);
    fcase(1'b0, 32'h8010_0040, TGT_PCI_MEM, 32'h8010_0040, 1'b0);
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    chk({27'h0, req_ready, tgt_sel}, 32'h10);
    chk(tgt_addr, 32'h0);
    lcase(1'b0, 32'hfec0_0000, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
